// File: hdl/iorb_ctrl.sv
// ROM and I/O peripheral bus controller behind the processor local bus
//
// Contract
// [RULE1] Peripheral side has separate 14-bit address and 16-bit data buses.
// [RULE2] State machine advances only on the inverted half-rate clock.
// [RULE3] Address strobe passes two half-rate flip-flops before use.
// [RULE4] Every output back to the processor is retimed to the core clock.
// [RULE5] Outputs to ROMs and I/O devices go out without retiming.
// [RULE6] Transceiver enable deassertion is aligned to core clock by J-K flop.
// [RULE7] Sixteen-bit width indication is retimed through D flip-flops.
// [RULE8] Wait counts reach fourteen, enough for a serial controller write.
// [RULE9] Inverted half-rate clock is the core clock divided by two.
// [RULE10] Claimed cycles assert width sixteen; ready only after wait expires.
// [RULE11] Processor holds address, direction and write data until ready.
`include "iorb_params.svh"
`default_nettype none
module iorb_ctrl
  import iorb_pkg::*;
#(
  parameter logic [`IORB_WAIT_W-1:0] WAIT_ROM = `IORB_WAIT_ROM,
  parameter logic [`IORB_WAIT_W-1:0] WAIT_INTC = `IORB_WAIT_INTC,
  parameter logic [`IORB_WAIT_W-1:0] WAIT_SER_RD = `IORB_WAIT_SER_RD,
  parameter logic [`IORB_WAIT_W-1:0] WAIT_SER_WR = `IORB_WAIT_SER_WR
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_address_strobe_n,
  input wire logic i_cpu_mem_io,
  input wire logic i_cpu_write,
  input wire logic [`IORB_CPU_ADDR_W-1:0] i_cpu_addr,
  input wire logic [`IORB_PER_DATA_W-1:0] i_cpu_wdata,
  output logic [`IORB_PER_DATA_W-1:0] o_cpu_rdata,
  output logic o_cpu_ready_n,
  output logic o_bus_width_sixteen_n,
  output logic o_transceiver_enable_n,
  output logic o_half_clk_n,
  output logic [`IORB_PER_ADDR_W-1:0] o_per_addr,
  output logic [`IORB_PER_DATA_W-1:0] o_per_wdata,
  output logic o_per_wdata_oe,
  input wire logic [`IORB_PER_DATA_W-1:0] i_per_rdata,
  output logic o_per_rd_n,
  output logic o_per_wr_n,
  output logic o_rom_cs_n,
  output logic o_intc_cs_n,
  output logic o_serial_cs_n
);
  localparam int AW = `IORB_PER_ADDR_W;
  localparam int DW = `IORB_PER_DATA_W;
  localparam int RQW = 1 + 1 + 1 + 3 + AW + DW;

  // ----------------------------------------------------------------------
  // Half-rate clock
  // ----------------------------------------------------------------------
  logic half_clk_n_q;
  logic tick;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_clk_n_q <= `IORB_RST_HALF_CLK;
    end else begin
      half_clk_n_q <= ~half_clk_n_q; // [RULE9]
    end
  end

  // Rising edge of the inverted half-rate clock is the next core edge
  assign tick = ~half_clk_n_q; // [RULE2]
  assign o_half_clk_n = half_clk_n_q;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [RQW-1:0] rq_raw;
  logic [RQW-1:0] rq_sync;
  logic [DW-1:0] prd_sync;
  logic s_strobe_n;
  logic s_mio;
  logic s_wr;
  logic [2:0] s_ahi;
  logic [AW-1:0] s_addr;
  logic [DW-1:0] s_wdata;

  assign rq_raw = {i_address_strobe_n, i_cpu_mem_io, i_cpu_write,
                   i_cpu_addr[`IORB_CPU_ADDR_W-1:`IORB_ROM_SEL_LSB],
                   i_cpu_addr[AW:`IORB_PER_ADDR_LSB], i_cpu_wdata};

  // Strobe and the request fields it qualifies share the same latency
  iorb_sync2 #(
    .WIDTH(RQW),
    .RST_VAL({`IORB_RST_STROBE_N, {(RQW-1){1'b0}}})
  ) u_req_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_async(rq_raw),
    .o_sync(rq_sync)
  ); // [RULE3]

  iorb_sync2 #(
    .WIDTH(DW),
    .RST_VAL({DW{1'b0}})
  ) u_rdata_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .i_async(i_per_rdata),
    .o_sync(prd_sync)
  );

  assign {s_strobe_n, s_mio, s_wr, s_ahi, s_addr, s_wdata} = rq_sync;

  // ----------------------------------------------------------------------
  // Decode and wait count selection
  // ----------------------------------------------------------------------
  iorb_dev_t hit;
  logic [`IORB_WAIT_W-1:0] wait_load;
  iorb_state_t state_q;
  iorb_dev_t dev_q;
  logic wr_q;

  always_comb begin
    hit = DEV_NONE;
    if (s_mio && (&s_ahi)) begin
      hit = DEV_ROM;
    end else if (!s_mio) begin
      hit = s_addr[`IORB_SER_SEL_BIT-1] ? DEV_SER : DEV_INTC;
    end
  end

  always_comb begin
    unique case (dev_q)
      DEV_ROM: wait_load = WAIT_ROM;
      DEV_INTC: wait_load = WAIT_INTC;
      DEV_SER: wait_load = wr_q ? WAIT_SER_WR : WAIT_SER_RD; // [RULE8]
      default: wait_load = WAIT_ROM;
    endcase
  end

  // ----------------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------------
  logic [`IORB_WAIT_W-1:0] cnt_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
    end else if (tick) begin // [RULE2]
      unique case (state_q)
        ST_IDLE: begin
          if (!s_strobe_n && hit != DEV_NONE) begin // [RULE3]
            state_q <= ST_ACCESS;
          end
        end
        ST_ACCESS: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (cnt_q == '0) begin // [RULE10]
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_RECOVER;
        // Strobe still low here would otherwise start a second cycle
        ST_RECOVER: begin
          if (s_strobe_n) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (state_q == ST_ACCESS) begin
        cnt_q <= wait_load; // [RULE8]
      end else if (state_q == ST_WAIT && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Request capture and peripheral side
  // ----------------------------------------------------------------------
  logic [AW-1:0] paddr_q;
  logic [DW-1:0] pwdata_q;
  logic active;

  // Fields are stable while the strobe is held, so one capture suffices
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dev_q <= DEV_NONE;
      wr_q <= 1'b0;
      paddr_q <= '0;
      pwdata_q <= '0;
    end else if (tick && state_q == ST_IDLE) begin // [RULE11]
      dev_q <= hit;
      wr_q <= s_wr;
      paddr_q <= s_addr;
      pwdata_q <= s_wdata;
    end
  end

  assign active = (state_q == ST_ACCESS) || (state_q == ST_WAIT) ||
                  (state_q == ST_DONE);

  // Peripherals are asynchronous; drive them straight from the state
  assign o_per_addr = paddr_q; // [RULE1]
  assign o_per_wdata = pwdata_q; // [RULE1]
  assign o_per_wdata_oe = active && wr_q; // [RULE5]
  assign o_per_rd_n = !(active && !wr_q); // [RULE5]
  assign o_per_wr_n = !(state_q == ST_WAIT && wr_q); // [RULE5]
  assign o_rom_cs_n = !(active && dev_q == DEV_ROM); // [RULE5]
  assign o_intc_cs_n = !(active && dev_q == DEV_INTC); // [RULE5]
  assign o_serial_cs_n = !(active && dev_q == DEV_SER); // [RULE5]

  // ----------------------------------------------------------------------
  // Returns to the processor, retimed on the core clock
  // ----------------------------------------------------------------------
  logic bus_width_sixteen_n_n_q;
  logic den_n_q;
  logic ready_n_q;
  logic [DW-1:0] rdata_q;
  logic jk_j;
  logic jk_k;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_width_sixteen_n_n_q <= 1'b1;
    end else begin
      bus_width_sixteen_n_n_q <= !active; // [RULE7] [RULE10]
    end
  end

  // J sets (deasserts) the enable, K clears it; release lands on a core edge
  assign jk_j = !active;
  assign jk_k = active;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      den_n_q <= 1'b1;
    end else begin
      den_n_q <= (jk_j && !den_n_q) || (!jk_k && den_n_q); // [RULE6]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ready_n_q <= 1'b1;
    end else begin
      ready_n_q <= !(tick && state_q == ST_DONE); // [RULE4] [RULE10]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (tick && state_q == ST_DONE && !wr_q) begin
      rdata_q <= prd_sync; // [RULE4]
    end
  end

  assign o_bus_width_sixteen_n = bus_width_sixteen_n_n_q;
  assign o_transceiver_enable_n = den_n_q;
  assign o_cpu_ready_n = ready_n_q;
  assign o_cpu_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [5:0] wait_cyc_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cyc_q <= '0;
    end else if (state_q == ST_WAIT) begin
      wait_cyc_q <= wait_cyc_q + 6'h1;
    end else begin
      wait_cyc_q <= '0;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // First edge out of reset would compare against a reset-held value
  property p_half_clk_div;
    $past(i_rst_n) |-> o_half_clk_n != $past(o_half_clk_n);
  endproperty
  a_half_clk_div: assert property (p_half_clk_div) // [RULE9]
    else $error("half-rate clock did not toggle");

  property p_state_on_tick;
    (state_q != $past(state_q)) |-> $past(tick);
  endproperty
  a_state_on_tick: assert property (p_state_on_tick) // [RULE2]
    else $error("state changed off the half-rate edge");

  property p_claim_needs_strobe;
    $rose(state_q == ST_ACCESS) |-> $past(!s_strobe_n && hit != DEV_NONE);
  endproperty
  a_claim_needs_strobe: assert property (p_claim_needs_strobe) // [RULE3]
    else $error("cycle claimed without synchronised strobe");

  property p_den_release;
    $fell(active) |-> !o_transceiver_enable_n ##1 o_transceiver_enable_n;
  endproperty
  a_den_release: assert property (p_den_release) // [RULE6]
    else $error("transceiver enable release not on next core edge");

  property p_bus_width_sixteen_n_follows;
    active |=> !o_bus_width_sixteen_n;
  endproperty
  a_bus_width_sixteen_n_follows: assert property (p_bus_width_sixteen_n_follows) // [RULE7]
    else $error("width sixteen not asserted during cycle");

  property p_ser_wr_wait;
    $rose(state_q == ST_DONE) && dev_q == DEV_SER && wr_q |->
      wait_cyc_q == 6'h1E;
  endproperty
  a_ser_wr_wait: assert property (p_ser_wr_wait) // [RULE8]
    else $error("serial write wait length wrong");

  property p_ready_after_done;
    !o_cpu_ready_n |-> $past(state_q == ST_DONE) && state_q == ST_RECOVER;
  endproperty
  a_ready_after_done: assert property (p_ready_after_done) // [RULE10]
    else $error("ready returned before wait expired");

  property p_ready_pulse;
    !o_cpu_ready_n |=> o_cpu_ready_n [*3];
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) // [RULE4]
    else $error("ready not a single core-cycle pulse");

  property p_one_select;
    $onehot0({!o_rom_cs_n, !o_intc_cs_n, !o_serial_cs_n});
  endproperty
  a_one_select: assert property (p_one_select) // [RULE5]
    else $error("more than one peripheral selected");
endmodule
`default_nettype wire

// File: shared/iorb_params.svh
// Offsets, widths and wait counts for the ROM and I/O bus controller
`ifndef IORB_PARAMS_SVH
`define IORB_PARAMS_SVH

// ----------------------------------------------------------------------
// Peripheral bus shape
// ----------------------------------------------------------------------
`define IORB_PER_ADDR_W 14
`define IORB_PER_DATA_W 16
`define IORB_CPU_ADDR_W 32
`define IORB_PER_ADDR_LSB 1
`define IORB_ROM_SEL_LSB 29
`define IORB_SER_SEL_BIT 6

// ----------------------------------------------------------------------
// Wait states, in half-rate clock periods
// ----------------------------------------------------------------------
`define IORB_WAIT_W 4
`define IORB_WAIT_ROM 4'h4
`define IORB_WAIT_INTC 4'h2
`define IORB_WAIT_SER_RD 4'h6
`define IORB_WAIT_SER_WR 4'hE

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IORB_RST_STROBE_N 1'h1
`define IORB_RST_HALF_CLK 1'h0

`endif

// File: shared/iorb_pkg.sv
// Types shared by the ROM and I/O bus controller
`default_nettype none
package iorb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_WAIT,
    ST_DONE,
    ST_RECOVER
  } iorb_state_t;

  typedef enum logic [1:0] {
    DEV_NONE,
    DEV_ROM,
    DEV_INTC,
    DEV_SER
  } iorb_dev_t;
endpackage
`default_nettype wire

// File: hdl/iorb_sync2.sv
// Two-stage synchroniser stepped on the half-rate clock phase
`default_nettype none
module iorb_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Both stages move only on the inverted half-rate clock edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (i_tick) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// File: sim/iorb_cpu_model.sv
// Processor local bus model issuing one bus cycle at a time
`default_nettype none
module iorb_cpu_model (
  input wire logic i_core_clk,
  input wire logic i_ready_n,
  output logic o_strobe_n,
  output logic o_mem_io,
  output logic o_write,
  output logic [31:0] o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_strobe_n = 1'b1;
    o_mem_io = 1'b0;
    o_write = 1'b0;
    o_addr = 32'h0000_0000;
    o_wdata = 16'h0000;
  end

  // ----------------------------------------------------------------------
  // One cycle; gives up after limit edges so an unclaimed cycle ends
  // ----------------------------------------------------------------------
  task automatic access(input logic mem, input logic wr,
      input logic [31:0] a, input logic [15:0] d, input int limit,
      output int cycles);
    cycles = 0;
    @(posedge i_core_clk);
    o_strobe_n <= 1'b0;
    o_mem_io <= mem;
    o_write <= wr;
    o_addr <= a;
    o_wdata <= d;
    do begin // Fields held until ready is sampled low or limit edges have passed
      @(posedge i_core_clk);
      cycles++;
    end while (i_ready_n !== 1'b0 && cycles < limit);
    o_strobe_n <= 1'b1;
    // Released fields show garbage so stale values cannot pass
    o_mem_io <= ~mem;
    o_write <= ~wr;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: sim/test_iorb_ctrl.sv
// Self-checking bench for the ROM and I/O bus controller
`include "iorb_params.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_iorb_ctrl
  import iorb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strobe_n, mem_io, wr, rdy_n, w16_n, en_n, half_n, per_oe;
  logic rd_n, wr_n, rom_n, intc_n, ser_n;
  logic [31:0] addr;
  logic [15:0] wdata, rdata, per_wd;
  logic [15:0] per_rd = 16'h0000;
  logic [13:0] per_a;
  logic [2:0] cs_seen = 3'b000;
  logic w16_seen = 1'b0;
  logic oe_seen = 1'b0;
  logic en_seen = 1'b0;
  logic [13:0] a_seen = 14'h0000;
  logic [15:0] wd_seen = 16'h0000;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  iorb_ctrl iorb_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_address_strobe_n(strobe_n), .i_cpu_mem_io(mem_io),
    .i_cpu_write(wr), .i_cpu_addr(addr), .i_cpu_wdata(wdata),
    .o_cpu_rdata(rdata), .o_cpu_ready_n(rdy_n),
    .o_bus_width_sixteen_n(w16_n), .o_transceiver_enable_n(en_n),
    .o_half_clk_n(half_n), .o_per_addr(per_a), .o_per_wdata(per_wd),
    .o_per_wdata_oe(per_oe), .i_per_rdata(per_rd), .o_per_rd_n(rd_n),
    .o_per_wr_n(wr_n), .o_rom_cs_n(rom_n), .o_intc_cs_n(intc_n),
    .o_serial_cs_n(ser_n));

  iorb_cpu_model iorb_cpu_model_inst (.i_core_clk(clk), .i_ready_n(rdy_n),
    .o_strobe_n(strobe_n), .o_mem_io(mem_io), .o_write(wr),
    .o_addr(addr), .o_wdata(wdata));

  // ----------------------------------------------------------------------
  // Peripheral stand-in and bus monitor
  // ----------------------------------------------------------------------
  // Data valid only while read strobe is low, garbage otherwise
  always @(posedge clk) begin
    if (rd_n === 1'b0) per_rd <= 16'h5A00 ^ {2'b00, per_a};
    else per_rd <= ~per_rd;
  end

  always @(negedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      finish_test();
    end
    if (rom_n === 1'b0) cs_seen[0] = 1'b1;
    if (intc_n === 1'b0) cs_seen[1] = 1'b1;
    if (ser_n === 1'b0) cs_seen[2] = 1'b1;
    if (cs_seen != 3'b000) a_seen = per_a;
    if (wr_n === 1'b0) wd_seen = per_wd;
    if (per_oe === 1'b1) oe_seen = 1'b1;
    if (en_n === 1'b0) en_seen = 1'b1;
    if (w16_n === 1'b0) w16_seen = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Shared bus cycle with checks
  // ----------------------------------------------------------------------
  task automatic do_acc(input logic mem, input logic w,
      input logic [31:0] a, input logic [15:0] d, input int wt,
      input logic [2:0] cs);
    int c;
    logic [15:0] old;
    old = rdata;
    @(posedge clk);
    cs_seen = 3'b000;
    w16_seen = 1'b0;
    oe_seen = 1'b0;
    en_seen = 1'b0;
    iorb_cpu_model_inst.access(mem, w, a, d, 2 * wt + 40, c);
    `CHK("select", cs, cs_seen)
    `CHK("width low", cs != 3'b000, w16_seen)
    `CHK("enable low", cs != 3'b000, en_seen)
    if (cs == 3'b000) begin
      `CHK("no answer", 1'b1, c == 2 * wt + 40)
    end else begin
      `CHK("ready time", 1'b1, c >= 2*wt+8 && c <= 2*wt+16)
      `CHK("address", a[14:1], a_seen)
      `CHK("drive on write", w, oe_seen)
      if (w) begin
        `CHK("wdata", d, wd_seen)
        `CHK("rdata kept", old, rdata)
      end else begin
        `CHK("rdata", 16'h5A00 ^ {2'b00, a[14:1]}, rdata)
      end
    end
    repeat (4) @(negedge clk);
    `CHK("enable released", 1'b1, en_n)
    `CHK("width released", 1'b1, w16_n)
    repeat (8) @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_clock;
    logic prev;
    repeat (20) @(posedge clk);
    `CHK("half clk in reset", 1'b0, half_n)
    `CHK("enable in reset", 1'b1, en_n)
    `CHK("ready in reset", 1'b1, rdy_n)
    rst_n <= 1'b1;
    @(negedge clk);
    prev = half_n;
    repeat (4) begin
      @(negedge clk);
      `CHK("half clk toggles", ~prev, half_n)
      prev = half_n;
    end
    $display("test reset_clock done");
  endtask

  task automatic t_rom_read;
    do_acc(1'b1, 1'b0, 32'hE000_2A56, 16'h0000, `IORB_WAIT_ROM, 3'b001);
    $display("test rom_read done");
  endtask

  task automatic t_intc_rw;
    do_acc(1'b0, 1'b1, 32'h0000_0024, 16'hC3A5, `IORB_WAIT_INTC, 3'b010);
    do_acc(1'b0, 1'b0, 32'h0000_0022, 16'h0000, `IORB_WAIT_INTC, 3'b010);
    $display("test intc_rw done");
  endtask

  // Slowest cycle right behind a read of the same device
  task automatic t_serial_rw;
    do_acc(1'b0, 1'b0, 32'h0000_7FC2, 16'h0000, `IORB_WAIT_SER_RD, 3'b100);
    do_acc(1'b0, 1'b1, 32'h0000_0040, 16'hFFFF, `IORB_WAIT_SER_WR, 3'b100);
    $display("test serial_rw done");
  endtask

  task automatic t_unmapped;
    do_acc(1'b1, 1'b0, 32'h2000_0010, 16'h0000, 0, 3'b000);
    $display("test unmapped done");
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    t_reset_clock();
    t_rom_read();
    t_intc_rw();
    t_serial_rw();
    t_unmapped();
    t_rom_read();
    finish_test();
  end
endmodule
`default_nettype wire
